// File: core/wrpc_cfg.svh
`ifndef WRPC_CFG_SVH
`define WRPC_CFG_SVH
// Voltage codes in millivolts, current codes in milliamps
`define WRPC_V_TARGET_HI 16'h1B58
`define WRPC_V_TARGET_R1 16'h189C
`define WRPC_V_TARGET_R2 16'h157C
`define WRPC_V_TARGET_R3 16'h154A
`define WRPC_V_OVERVOLT 16'h3A98
`define WRPC_V_RUN 16'h1B58
`define WRPC_OUTPUT_CURRENT_LIMIT_NUM 32'h0000AFC8
`define WRPC_LOAD_REGION_REFERENCE_NUM 32'h00009470
`define WRPC_OUTPUT_CURRENT_LIMIT_CAP 16'h07D0
`define WRPC_LIMIT_SET_RESISTOR_MIN 16'h0019
`define WRPC_DUMMY_RELEASE_MA 16'h000F
`define WRPC_OFFSET_MAX_MW 16'h012C
`define WRPC_CURVE_COUNT 4'hA
`define WRPC_EOP_OVERTEMP 8'h03
`define WRPC_EOC_CHARGED 8'h01
`define WRPC_EOP_OVERCURRENT 8'h04
`define WRPC_EOP_OVERVOLT 8'h05
`define WRPC_RP_PERIOD_US 32'd1000
`define WRPC_CLK_MHZ 32'd10
`define WRPC_RP_CYCLES (`WRPC_RP_PERIOD_US * `WRPC_CLK_MHZ)
`endif

// File: core/wrpc_ctrl.sv
`timescale 1ns/1ps
`include "wrpc_cfg.svh"
// What this block does
// - Take periodic voltage and current samples
// - Below target, ask lower frequency
// - Above target, ask higher frequency
// - Keep 15mA dummy load during startup
// - After ID/config, regulate rectified supply 7V
// - Enable regulator after supply first reaches 7V
// - Send received-power packet periodically in transfer
// - Select one of 10 stored loss curves
// - Volatile host setting overrides stored curves
// - Add decoded signed offset in mW, not clamped to -300 to +300mW
// - Above 15V disable regulator, drive below 7V
// - Clamp above threshold, release below hysteresis
// - Overcurrent or overtemperature: disable, end power
// - Current limit 45000/R, capped 2A
// - Region reference 38000/R
// - Target 7, 6.3, 5.5, 5.45V by region
// - Above 7V pick half/full synchronous mode
// - Switches off under lockout, synchronous after bias
// - Thermal request: disable, end power code 03
// - Charge-done request: end-of-charge code 01
// - Transfer indicator low while regulator enabled
// - Fault indicator low on protection event
module wrpc_ctrl (
  input wire logic core_clk, // 10 MHz clock
  input wire logic nrst, // Async reset, active low
  input wire logic sample_valid, // Converter sample strobe
  input wire logic [15:0] rectified_supply, // Rectified supply, mV
  input wire logic [15:0] output_load_current, // Load current, mA
  input wire logic [15:0] limit_set_resistor, // Limit resistor, kOhm
  input wire logic [3:0] loss_curve_select_resistor, // Decoded curve index
  input wire logic signed [15:0] loss_offset_resistor, // Decoded offset, mW
  input wire logic [159:0] curve_otp, // Ten 16-bit stored curve values, mW
  input wire logic [15:0] host_curve, // Volatile host setting, mW
  input wire logic host_curve_sel, // Host setting overrides stored
  input wire logic [15:0] clamp_threshold, // Clamp threshold, mV
  input wire logic [15:0] clamp_hysteresis, // Clamp hysteresis, mV
  input wire logic input_undervoltage_lockout, // High while under lockout
  input wire logic bias_ready, // Internal bias enabled
  input wire logic coil_input_a, // AC polarity comparator A
  input wire logic coil_input_b, // AC polarity comparator B
  input wire logic die_overtemp, // Die over shutdown level
  input wire logic thermal_shutdown_request, // External thermal request
  input wire logic charge_done_request, // Charge-done request
  input wire logic pkt_ready, // Modulator accepts packet
  output logic pkt_valid, // Packet request
  output wrpc_pkg::wrpc_pkt_t pkt_kind, // Packet type
  output logic [7:0] pkt_data, // Packet payload byte
  output logic signed [15:0] pkt_word, // Error or power value
  output logic dummy_load_en, // Startup dummy load on
  output logic regulator_en, // Output regulator enable
  output logic clamp_en, // Both clamp switches on
  output logic rect_sync_en, // Rectifier switches driven
  output logic rect_full_sync, // Full synchronous mode
  output logic [1:0] rect_gate, // Low-side gate drive a/b
  output logic [15:0] output_current_limit, // Current limit, mA
  output logic [15:0] load_region_reference, // Region reference, mA
  output logic [15:0] rectified_supply_target, // Active target, mV
  output logic xfer_active_n, // Low while regulator enabled
  output logic fault_n // Low after protection event
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  wrpc_pkg::wrpc_phase_t phase_q;
  logic [15:0] v_q;
  logic [15:0] i_q;
  logic new_q;
  logic reached7_q;
  logic ovp_q;
  logic oc_q;
  logic ot_q;
  logic chg_q;
  logic [31:0] rp_cnt_q;
  logic rp_due_q;
  logic div_go_q;
  logic div_sel_q;
  logic [15:0] div_quo;
  logic div_done;
  logic clamp_hit;
  logic [15:0] comp_mw;
  logic signed [17:0] power_sum;
  logic [31:0] pwr_raw;

  // ************************************
  // Reset release
  // ************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ************************************
  // Sample capture
  // ************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      v_q <= 16'h0000;
      i_q <= 16'h0000;
      new_q <= 1'b0;
    end else begin
      new_q <= sample_valid;
      if (sample_valid) begin
        v_q <= rectified_supply;
        i_q <= output_load_current;
      end
    end
  end

  // ************************************
  // Limit and reference division
  // ************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_go_q <= 1'b1;
      div_sel_q <= 1'b0;
      output_current_limit <= `WRPC_OUTPUT_CURRENT_LIMIT_CAP;
      load_region_reference <= 16'h0000;
    end else begin
      div_go_q <= 1'b0;
      if (div_done) begin
        div_sel_q <= ~div_sel_q;
        div_go_q <= 1'b1;
        if (!div_sel_q) begin
          if (limit_set_resistor < `WRPC_LIMIT_SET_RESISTOR_MIN || div_quo > `WRPC_OUTPUT_CURRENT_LIMIT_CAP) begin
            output_current_limit <= `WRPC_OUTPUT_CURRENT_LIMIT_CAP;
          end else begin
            output_current_limit <= div_quo;
          end
        end else begin
          load_region_reference <= div_quo;
        end
      end
    end
  end

  wrpc_divider u_div (
    .clk(core_clk),
    .rst_n(rst_n),
    .start(div_go_q),
    .num(div_sel_q ? `WRPC_LOAD_REGION_REFERENCE_NUM : `WRPC_OUTPUT_CURRENT_LIMIT_NUM),
    .den((limit_set_resistor == 16'h0000) ? 16'h0001 : limit_set_resistor),
    .quo(div_quo),
    .done(div_done)
  );

  // ************************************
  // Region target
  // ************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rectified_supply_target <= `WRPC_V_TARGET_HI;
    end else if (sample_valid) begin
      if (phase_q != wrpc_pkg::PH_TRANSFER || !reached7_q || ovp_q) begin
        rectified_supply_target <= `WRPC_V_TARGET_HI;
      end else if ({4'h0, output_load_current} * 20'd10 < {4'h0, load_region_reference}) begin
        rectified_supply_target <= `WRPC_V_TARGET_HI;
      end else if ({4'h0, output_load_current} * 20'd5 < {4'h0, load_region_reference}) begin
        rectified_supply_target <= `WRPC_V_TARGET_R1;
      end else if ({4'h0, output_load_current} * 20'd5 < {3'h0, load_region_reference, 1'b0}) begin
        rectified_supply_target <= `WRPC_V_TARGET_R2;
      end else begin
        rectified_supply_target <= `WRPC_V_TARGET_R3;
      end
    end
  end

  // ************************************
  // Protection state
  // ************************************
  wrpc_hyst u_clamp (
    .clk(core_clk),
    .rst_n(rst_n),
    .sample(sample_valid),
    .level(rectified_supply),
    .hi(clamp_threshold),
    .hys(clamp_hysteresis),
    .active(clamp_hit)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovp_q <= 1'b0;
      oc_q <= 1'b0;
      ot_q <= 1'b0;
      chg_q <= 1'b0;
      clamp_en <= 1'b0;
      fault_n <= 1'b1;
    end else begin
      clamp_en <= clamp_hit;
      if (new_q && v_q > `WRPC_V_OVERVOLT) begin
        ovp_q <= 1'b1;
      end else if (new_q && v_q < `WRPC_V_RUN) begin
        ovp_q <= 1'b0;
      end
      if (new_q && i_q >= output_current_limit) begin
        oc_q <= 1'b1;
      end
      if (die_overtemp || thermal_shutdown_request) begin
        ot_q <= 1'b1;
      end
      if (charge_done_request) begin
        chg_q <= 1'b1;
      end
      if (oc_q || ot_q || ovp_q || clamp_hit) begin
        fault_n <= 1'b0;
      end
    end
  end

  // ************************************
  // Phase sequencing and regulator
  // ************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= wrpc_pkg::PH_SELECT;
      reached7_q <= 1'b0;
      regulator_en <= 1'b0;
      xfer_active_n <= 1'b1;
      dummy_load_en <= 1'b1;
    end else begin
      case (phase_q)
        wrpc_pkg::PH_SELECT: begin
          if (!input_undervoltage_lockout && bias_ready) begin
            phase_q <= wrpc_pkg::PH_PING;
          end
        end
        wrpc_pkg::PH_PING: begin
          if (pkt_valid && pkt_ready && pkt_kind == wrpc_pkg::PK_SIG_STRENGTH) begin
            phase_q <= wrpc_pkg::PH_IDCFG;
          end
        end
        wrpc_pkg::PH_IDCFG: begin
          if (pkt_valid && pkt_ready && pkt_kind == wrpc_pkg::PK_CONFIG) begin
            phase_q <= wrpc_pkg::PH_TRANSFER;
          end
        end
        wrpc_pkg::PH_TRANSFER: begin
          if (pkt_valid && pkt_ready && pkt_kind == wrpc_pkg::PK_END_POWER) begin
            phase_q <= wrpc_pkg::PH_STOPPED;
          end
        end
        wrpc_pkg::PH_STOPPED: begin
          phase_q <= wrpc_pkg::PH_STOPPED;
        end
        default: begin
          phase_q <= wrpc_pkg::PH_SELECT;
        end
      endcase
      if (phase_q == wrpc_pkg::PH_TRANSFER && new_q && v_q >= `WRPC_V_RUN) begin
        reached7_q <= 1'b1;
      end
      regulator_en <= reached7_q && !ovp_q && !oc_q && !ot_q
                      && phase_q == wrpc_pkg::PH_TRANSFER;
      xfer_active_n <= !regulator_en;
      if (i_q > `WRPC_DUMMY_RELEASE_MA && regulator_en) begin
        dummy_load_en <= 1'b0;
      end else if (phase_q != wrpc_pkg::PH_TRANSFER) begin
        dummy_load_en <= 1'b1;
      end
    end
  end

  // ************************************
  // Rectifier switching
  // ************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rect_sync_en <= 1'b0;
      rect_full_sync <= 1'b0;
      rect_gate <= 2'h0;
    end else begin
      rect_sync_en <= !input_undervoltage_lockout && bias_ready;
      if (v_q > `WRPC_V_RUN) begin
        rect_full_sync <= ({4'h0, i_q} * 20'd10) >= {4'h0, load_region_reference};
      end
      if (input_undervoltage_lockout || !bias_ready) begin
        rect_gate <= 2'h0;
      end else begin
        rect_gate <= {coil_input_b & ~coil_input_a,
                      coil_input_a & ~coil_input_b};
      end
    end
  end

  // ************************************
  // Received-power interval timer
  // ************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rp_cnt_q <= 32'h00000000;
      rp_due_q <= 1'b0;
    end else begin
      // Clear first so a new period end wins
      if (pkt_valid && pkt_ready && pkt_kind == wrpc_pkg::PK_RX_POWER) begin
        rp_due_q <= 1'b0;
      end
      if (phase_q != wrpc_pkg::PH_TRANSFER) begin
        rp_cnt_q <= 32'h00000000;
      end else if (rp_cnt_q == `WRPC_RP_CYCLES - 32'd1) begin
        rp_cnt_q <= 32'h00000000;
        rp_due_q <= 1'b1;
      end else begin
        rp_cnt_q <= rp_cnt_q + 32'd1;
      end
    end
  end

  // Loss compensation and received power in mW
  assign comp_mw = host_curve_sel ? host_curve :
                   (loss_curve_select_resistor < `WRPC_CURVE_COUNT) ?
                   curve_otp[loss_curve_select_resistor * 16 +: 16] : 16'h0000;
  assign pwr_raw = v_q * i_q / 32'd1000;
  assign power_sum = $signed({2'b00, pwr_raw[15:0]}) + $signed({2'b00, comp_mw})
                     + $signed({{2{loss_offset_resistor[15]}}, loss_offset_resistor});

  // ************************************
  // Packet issue
  // ************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pkt_valid <= 1'b0;
      pkt_kind <= wrpc_pkg::PK_NONE;
      pkt_data <= 8'h00;
      pkt_word <= 16'h0000;
    end else if (!pkt_valid || pkt_ready) begin
      pkt_valid <= 1'b0;
      pkt_kind <= wrpc_pkg::PK_NONE;
      // Phase-closing packets leave one idle cycle
      if (pkt_valid && (pkt_kind == wrpc_pkg::PK_END_POWER
          || pkt_kind == wrpc_pkg::PK_SIG_STRENGTH || pkt_kind == wrpc_pkg::PK_CONFIG)) begin
        pkt_valid <= 1'b0;
      end else if (phase_q == wrpc_pkg::PH_PING) begin
        pkt_valid <= 1'b1;
        pkt_kind <= wrpc_pkg::PK_SIG_STRENGTH;
        pkt_data <= v_q[15:8];
      end else if (phase_q == wrpc_pkg::PH_IDCFG) begin
        pkt_valid <= 1'b1;
        pkt_kind <= (pkt_kind == wrpc_pkg::PK_ID) ? wrpc_pkg::PK_CONFIG : wrpc_pkg::PK_ID;
      end else if (phase_q == wrpc_pkg::PH_TRANSFER) begin
        if (ot_q || oc_q || chg_q) begin
          pkt_valid <= 1'b1;
          pkt_kind <= wrpc_pkg::PK_END_POWER;
          pkt_data <= ot_q ? `WRPC_EOP_OVERTEMP :
                      oc_q ? `WRPC_EOP_OVERCURRENT : `WRPC_EOC_CHARGED;
        end else if (rp_due_q) begin
          pkt_valid <= 1'b1;
          pkt_kind <= wrpc_pkg::PK_RX_POWER;
          pkt_word <= power_sum[17] ? 16'h0000 : power_sum[15:0];
        end else if (new_q) begin
          pkt_valid <= 1'b1;
          pkt_kind <= wrpc_pkg::PK_CTRL_ERR;
          pkt_word <= rectified_supply_target - v_q;
        end
      end
    end
  end
endmodule

// File: core/wrpc_divider.sv
`timescale 1ns/1ps
// Serial restoring divider, one quotient bit per clock
module wrpc_divider (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous copy of reset
  input wire logic start, // Begin a division
  input wire logic [31:0] num, // Dividend
  input wire logic [15:0] den, // Divisor
  output logic [15:0] quo, // Quotient, saturated to 16'hFFFF above 16 bits
  output logic done // One-cycle pulse when quo is valid
);
  logic [31:0] q_q;
  logic [31:0] r_q;
  logic [5:0] cnt_q;
  logic busy_q;
  logic [32:0] trial;

  assign trial = {r_q, q_q[31]} - {17'h00000, den};

  // ************************************
  // Iteration
  // ************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_q <= 32'h00000000;
      r_q <= 32'h00000000;
      cnt_q <= 6'h00;
      busy_q <= 1'b0;
      done <= 1'b0;
      quo <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (start && !busy_q) begin
        q_q <= num;
        r_q <= 32'h00000000;
        cnt_q <= 6'h20;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (!trial[32]) begin
          r_q <= trial[31:0];
          q_q <= {q_q[30:0], 1'b1};
        end else begin
          r_q <= {r_q[30:0], q_q[31]};
          q_q <= {q_q[30:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy_q <= 1'b0;
          done <= 1'b1;
          quo <= (q_q[30:15] != 16'h0000) ? 16'hFFFF :
                 (trial[32] ? {q_q[14:0], 1'b0} : {q_q[14:0], 1'b1});
        end
      end
    end
  end
endmodule

// File: core/wrpc_hyst.sv
`timescale 1ns/1ps
// Comparator with hysteresis: sets above hi, clears below hi minus hys
module wrpc_hyst (
  input wire logic clk, // Core clock
  input wire logic rst_n, // Synchronous copy of reset
  input wire logic sample, // New sample strobe
  input wire logic [15:0] level, // Sampled value
  input wire logic [15:0] hi, // Set threshold
  input wire logic [15:0] hys, // Hysteresis width
  output logic active // Comparator state
);
  // ************************************
  // Hysteresis state
  // ************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active <= 1'b0;
    end else if (sample) begin
      if (level > hi) begin
        active <= 1'b1;
      end else if ({1'b0, level} < ({1'b0, hi} - {1'b0, hys})) begin
        active <= 1'b0;
      end
    end
  end
endmodule

// File: core/wrpc_pkg.sv
package wrpc_pkg;
  typedef enum logic [2:0] {
    PH_SELECT, PH_PING, PH_IDCFG, PH_TRANSFER, PH_STOPPED
  } wrpc_phase_t;
  typedef enum logic [2:0] {
    PK_NONE, PK_SIG_STRENGTH, PK_ID, PK_CONFIG, PK_CTRL_ERR, PK_RX_POWER,
    PK_END_POWER
  } wrpc_pkt_t;
endpackage

// File: test/tb_top.sv
`timescale 1ns/1ps
// ****
// Bench for the power controller
// ****
module tb_top;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic sample_valid = 1'b0;
  logic [15:0] rectified_supply = 16'h1388;
  logic [15:0] output_load_current = 16'h0000;
  logic [15:0] limit_set_resistor = 16'h0026;
  logic [3:0] loss_curve_select_resistor = 4'h3;
  logic signed [15:0] loss_offset_resistor = 16'hFF38;
  logic [159:0] curve_otp = {10{16'h0064}};
  logic [15:0] host_curve = 16'h00C8;
  logic host_curve_sel = 1'b0;
  logic [15:0] clamp_threshold = 16'h2328;
  logic [15:0] clamp_hysteresis = 16'h01F4;
  logic input_undervoltage_lockout = 1'b1;
  logic bias_ready = 1'b0;
  logic coil_input_a = 1'b0;
  logic coil_input_b;
  logic die_overtemp = 1'b0;
  logic thermal_shutdown_request = 1'b0;
  logic charge_done_request = 1'b0;
  logic slow = 1'b0;
  logic pkt_ready, pkt_valid, dummy_load_en, regulator_en, clamp_en, rect_sync_en;
  logic rect_full_sync, xfer_active_n, fault_n;
  logic [1:0] rect_gate;
  logic [7:0] pkt_data, last_data;
  logic signed [15:0] pkt_word, last_word;
  logic [15:0] output_current_limit, load_region_reference, rectified_supply_target;
  logic [15:0] n_pkt, n_ctrl, n_rp;
  wrpc_pkg::wrpc_pkt_t pkt_kind, last_kind;
  wrpc_pkg::wrpc_pkt_t kinds [3] = '{wrpc_pkg::PK_SIG_STRENGTH, wrpc_pkg::PK_ID,
    wrpc_pkg::PK_CONFIG};
  logic [15:0] loads [4] = '{16'h0032, 16'h0096, 16'h012C, 16'h01F4};
  logic [15:0] tgts [4] = '{16'h1B58, 16'h189C, 16'h157C, 16'h154A};
  logic [15:0] cvs [3] = '{16'h251C, 16'h21FC, 16'h20D0};
  logic [7:0] codes [4] = '{8'h04, 8'h03, 8'h03, 8'h01};
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;

  assign coil_input_b = ~coil_input_a;
  wrpc_ctrl wrpc_ctrl_i (.*);
  wrpc_tx_model wrpc_tx_model_i (.*);

  // Clock and coil polarity
  always #50 core_clk = ~core_clk;
  always #400 coil_input_a = ~coil_input_a;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // One sample, then wait for its control error packet
  task automatic samp(input logic [15:0] v, input logic [15:0] i);
    logic [15:0] n0;
    int t;
    n0 = n_ctrl;
    rectified_supply = v;
    output_load_current = i;
    sample_valid = 1'b1;
    @(negedge core_clk);
    sample_valid = 1'b0;
    t = 0;
    while (n_ctrl == n0 && t < 200) begin
      @(negedge core_clk);
      t++;
    end
    chk(n_ctrl - n0, 16'h0001);
  endtask

  // Reset, release lockout, walk the startup packets
  task automatic start_run(input logic s, input logic [15:0] r);
    int t;
    nrst = 1'b0;
    input_undervoltage_lockout = 1'b1;
    bias_ready = 1'b0;
    die_overtemp = 1'b0;
    thermal_shutdown_request = 1'b0;
    charge_done_request = 1'b0;
    slow = s;
    host_curve_sel = s;
    limit_set_resistor = r;
    rectified_supply = 16'h1388;
    output_load_current = 16'h0000;
    repeat (8) @(negedge core_clk);
    chk(regulator_en, 16'h0000);
    chk(dummy_load_en, 16'h0001);
    chk(xfer_active_n, 16'h0001);
    chk(fault_n, 16'h0001);
    chk(rectified_supply_target, 16'h1B58);
    nrst = 1'b1;
    repeat (100) @(negedge core_clk);
    chk(rect_sync_en, 16'h0000);
    input_undervoltage_lockout = 1'b0;
    bias_ready = 1'b1;
    for (int k = 0; k < 3; k++) begin
      t = 0;
      while (n_pkt == 16'(k) && t < 400) begin
        sample_valid = (t % 16 == 0);
        @(negedge core_clk);
        t++;
      end
      sample_valid = 1'b0;
      chk(last_kind, kinds[k]);
    end
    repeat (40) @(negedge core_clk);
    chk(rect_sync_en, 16'h0001);
  endtask

  // Cycle ceiling
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      results();
    end
  end

  // Main sequence
  initial begin
    int t;
    start_run(1'b0, 16'h0026);
    samp(16'h1770, 16'h0000);
    chk(last_word, 16'h03E8);
    chk(regulator_en, 16'h0000);
    samp(16'h1C20, 16'h0000);
    chk(last_word, 16'hFF38);
    chk(regulator_en, 16'h0001);
    chk(xfer_active_n, 16'h0000);
    chk(output_current_limit, 16'h04A0);
    chk(load_region_reference, 16'h03E8);
    chk(rect_full_sync, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      samp(16'h1770, loads[k]);
      chk(rectified_supply_target, tgts[k]);
      chk(last_word, tgts[k] - 16'h1770);
    end
    chk(dummy_load_en, 16'h0000);
    for (int k = 0; k < 3; k++) begin
      samp(cvs[k], 16'h01F4);
      chk(clamp_en, 16'(k < 2));
    end
    chk(rect_full_sync, 16'h0001);
    repeat (10100) @(negedge core_clk);
    chk(n_rp != 16'h0000, 16'h0001);
    chk(last_word, 16'h1004);
    samp(16'h3E80, 16'h0032);
    chk(regulator_en, 16'h0000);
    chk(fault_n, 16'h0000);
    chk(last_word, 16'hDCD8);
    for (int c = 0; c < 4; c++) begin
      start_run(c[0], (c == 1) ? 16'h0014 : 16'h0026);
      samp(16'h1C20, 16'h0032);
      chk(regulator_en, 16'h0001);
      if (c == 1) chk(output_current_limit, 16'h07D0);
      case (c)
        0: samp(16'h1B58, 16'h0514);
        1: thermal_shutdown_request = 1'b1;
        2: die_overtemp = 1'b1;
        default: charge_done_request = 1'b1;
      endcase
      t = 0;
      while (last_kind !== wrpc_pkg::PK_END_POWER && t < 300) begin
        @(negedge core_clk);
        t++;
      end
      chk(last_data, codes[c]);
      if (c < 3) chk(regulator_en, 16'h0000);
      if (c == 0) chk(fault_n, 16'h0000);
    end
    results();
  end
endmodule

bind wrpc_ctrl wrpc_ctrl_props wrpc_ctrl_props_i (.*);

// File: test/wrpc_ctrl_props.sv
`timescale 1ns/1ps
// ****
// Port checker for the power controller
// ****
module wrpc_ctrl_props (
  input wire logic core_clk, // Core clock
  input wire logic nrst, // Reset, active low
  input wire logic sample_valid, // Sample strobe
  input wire logic [15:0] rectified_supply, // Supply, mV
  input wire logic [15:0] output_load_current, // Load, mA
  input wire logic [15:0] clamp_threshold, // Clamp level, mV
  input wire logic [15:0] clamp_hysteresis, // Clamp hysteresis, mV
  input wire logic input_undervoltage_lockout, // Lockout
  input wire logic die_overtemp, // Die too hot
  input wire logic thermal_shutdown_request, // Thermal request
  input wire logic pkt_ready, // Packet taken
  input wire logic pkt_valid, // Packet offered
  input wire wrpc_pkg::wrpc_pkt_t pkt_kind, // Packet type
  input wire logic [7:0] pkt_data, // Payload byte
  input wire logic signed [15:0] pkt_word, // Payload word
  input wire logic regulator_en, // Regulator on
  input wire logic clamp_en, // Clamp on
  input wire logic rect_sync_en, // Switches driven
  input wire logic [1:0] rect_gate, // Gate drive
  input wire logic [15:0] load_region_reference, // Reference, mA
  input wire logic [15:0] rectified_supply_target, // Target, mV
  input wire logic xfer_active_n, // Transfer indicator
  input wire logic fault_n // Fault indicator
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  // Indicator follows the regulator
  reg_xfer_a: assert property ($rose(regulator_en) |-> ##[0:1] !xfer_active_n)
    else $error("transfer indicator not low with regulator on");
  // Offered packet holds until taken
  pkt_hold_a: assert property (pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_kind)
    && $stable(pkt_data) && $stable(pkt_word))
    else $error("packet changed before it was taken");
  // Switches idle under lockout
  lockout_gate_a: assert property (input_undervoltage_lockout [*2] |->
    !rect_sync_en && rect_gate == 2'b00)
    else $error("rectifier driven under lockout");
  // Over 15V drops the regulator
  ovp_off_a: assert property (sample_valid && rectified_supply > 16'h3A98 |->
    ##[1:3] !regulator_en && !fault_n)
    else $error("regulator left on above 15V");
  // Clamp set and release
  clamp_set_a: assert property (sample_valid && rectified_supply > clamp_threshold |->
    ##[1:2] clamp_en)
    else $error("clamp not on above threshold");
  clamp_rel_a: assert property (sample_valid &&
    rectified_supply < clamp_threshold - clamp_hysteresis |-> ##[1:2] !clamp_en)
    else $error("clamp not released below hysteresis");
  // Thermal causes drop the regulator
  temp_req_a: assert property ($rose(thermal_shutdown_request) |-> ##[1:4] !regulator_en)
    else $error("regulator left on after thermal request");
  die_temp_a: assert property (die_overtemp |-> ##[1:4] !regulator_en)
    else $error("regulator left on with die too hot");
  // Target by load region
  load_low_a: assert property (sample_valid &&
    output_load_current * 10 < load_region_reference |-> ##2 rectified_supply_target == 16'h1B58)
    else $error("wrong target for light load");
  load_high_a: assert property (sample_valid && regulator_en &&
    output_load_current * 10 > load_region_reference * 4 |->
    ##2 rectified_supply_target == 16'h154A)
    else $error("wrong target for heavy load");
endmodule

// File: test/wrpc_tx_model.sv
`timescale 1ns/1ps
// ****
// Transmitter side: takes packets promptly or slowly
// ****
module wrpc_tx_model (
  input wire logic core_clk, // Core clock
  input wire logic nrst, // Reset, active low
  input wire logic slow, // Stretch each answer
  input wire logic pkt_valid, // Packet offered
  input wire wrpc_pkg::wrpc_pkt_t pkt_kind, // Packet type
  input wire logic [7:0] pkt_data, // Payload byte
  input wire logic signed [15:0] pkt_word, // Payload word
  output logic pkt_ready, // Packet taken
  output logic [15:0] n_pkt, // Packets taken
  output logic [15:0] n_ctrl, // Control error packets taken
  output logic [15:0] n_rp, // Received-power packets taken
  output wrpc_pkg::wrpc_pkt_t last_kind, // Last type taken
  output logic [7:0] last_data, // Last byte taken
  output logic signed [15:0] last_word // Last word taken
);
  logic [3:0] wait_q;

  // Handshake and packet log
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pkt_ready <= 1'b0;
      wait_q <= 4'h0;
      n_pkt <= 16'h0000;
      n_ctrl <= 16'h0000;
      n_rp <= 16'h0000;
      last_kind <= wrpc_pkg::PK_NONE;
      last_data <= 8'h00;
      last_word <= 16'h0000;
    end else if (pkt_valid && pkt_ready) begin
      pkt_ready <= 1'b0;
      wait_q <= 4'h0;
      n_pkt <= n_pkt + 16'h0001;
      n_ctrl <= n_ctrl + 16'(pkt_kind == wrpc_pkg::PK_CTRL_ERR);
      n_rp <= n_rp + 16'(pkt_kind == wrpc_pkg::PK_RX_POWER);
      last_kind <= pkt_kind;
      last_data <= pkt_data;
      last_word <= pkt_word;
    end else if (pkt_valid) begin
      wait_q <= wait_q + 4'h1;
      pkt_ready <= (wait_q >= (slow ? 4'h6 : 4'h0));
    end
  end
endmodule
